// ### src/aip_post_proc.v
// Analog input post-processing: filter, scaling, clamp, limits, format.
// Assumes the front end converts on conv_req and that register
// accesses and samples arrive as one-cycle strobes in the clock domain.
`timescale 1ns/1ps
`include "aip_defs.vh"

module aip_post_proc #(
  parameter integer CONV_CYCLES   = `AIP_CONV_US * `AIP_CLK_MHZ,
  parameter integer CONV60_CYCLES = `AIP_CONV60_NS * `AIP_CLK_MHZ / 1000,
  parameter integer WDOG_CYCLES   = `AIP_WDOG_MS * 1000 * `AIP_CLK_MHZ,
  parameter integer FOUR_CH       = 0
) (
  input  wire                 clock,
  input  wire                 reset,
  output wire                 conv_req,
  input  wire                 sample_valid,
  input  wire [`AIP_CH_W-1:0] sample_ch,
  input  wire [15:0]          sample_data,
  output reg                  res_valid_q,
  output reg  [`AIP_CH_W-1:0] res_ch_q,
  output reg  [15:0]          res_data_q,
  output reg  [7:0]           res_status_q,
  input  wire                 host_refresh,
  input  wire                 reg_stb,
  input  wire [`AIP_CH_W-1:0] reg_ch,
  input  wire [7:0]           reg_ctrl,
  input  wire [15:0]          reg_wdata,
  output reg                  reg_ack_q,
  output reg  [7:0]           reg_status_q,
  output reg  [15:0]          reg_rdata_q
);

  localparam integer NCH = 1 << `AIP_CH_W;

  reg        [15:0] mode_q     [0:NCH-1];
  reg        [15:0] fsel_q     [0:NCH-1];
  reg        [15:0] mfr_ofs_q  [0:NCH-1];
  reg        [15:0] mfr_gain_q [0:NCH-1];
  reg        [15:0] upper_q    [0:NCH-1];
  reg        [15:0] lower_q    [0:NCH-1];
  reg        [15:0] usr_ofs_q  [0:NCH-1];
  reg        [15:0] usr_gain_q [0:NCH-1];
  reg        [15:0] lim1_q     [0:NCH-1];
  reg        [15:0] lim2_q     [0:NCH-1];
  reg signed [15:0] hist_q     [0:NCH*16-1];
  reg [`AIP_HIST_W-1:0] ptr_q  [0:NCH-1];
  reg signed [19:0] sum_q      [0:NCH-1];
  reg signed [23:0] iir_q      [0:NCH-1];
  reg        [23:0] conv_cnt_q;
  reg        [27:0] wdog_cnt_q;
  reg               wdog_exp_q;
  integer           i;

  // Saturate a wide signed value into 16 bits
  function [15:0] sat16;
    input signed [33:0] v;
    begin
      if (v > 34'sh0_7fff)
        sat16 = 16'h7fff;
      else if (v < -34'sh0_8000)
        sat16 = 16'h8000;
      else
        sat16 = v[15:0];
    end
  endfunction

  // Per-sample datapath, one cycle from sample to result
  reg signed [15:0] x, p1, p2, old, filt, m16;
  reg signed [17:0] fir2;
  reg signed [19:0] sum_d;
  reg signed [23:0] iir_d, iir_err;
  reg signed [33:0] mfr_w, usr_w, cl_w;
  reg        [15:0] mode, fsel, v, pd;
  reg        [3:0]  k;
  reg               iir_on, over, under;
  reg        [1:0]  cmp1, cmp2;
  reg [`AIP_HIST_W-1:0] pt, pm1, pm2;
  reg [`AIP_CH_W+`AIP_HIST_W-1:0] hb;

  always @* begin
    x    = sample_data;
    mode = mode_q[sample_ch];
    fsel = (FOUR_CH != 0) ? `AIP_F_FIR2 : fsel_q[sample_ch];
    pt   = ptr_q[sample_ch];
    hb   = {sample_ch, {`AIP_HIST_W{1'b0}}};
    // Wrap inside the channel's own slots, never into the next channel
    pm1  = pt - 4'h1;
    pm2  = pt - 4'h2;
    p1   = hist_q[hb | pm1];
    p2   = hist_q[hb | pm2];
    old  = hist_q[hb | pt];
    fir2 = ({{2{x[15]}}, x} + {p1[15], p1, 1'b0}
           + {{2{p2[15]}}, p2}) >>> `AIP_FIR2_SHIFT;
    sum_d = sum_q[sample_ch] + {{4{x[15]}}, x}
            - {{4{old[15]}}, old};
    iir_on = 1'b1;
    case (fsel)
      `AIP_F_IIR_1K:  k = 4'h1;
      `AIP_F_IIR_100: k = 4'h3;
      `AIP_F_IIR_50:  k = 4'h4;
      `AIP_F_IIR_20:  k = 4'h5;
      `AIP_F_IIR_10:  k = 4'h6;
      `AIP_F_IIR_5:   k = 4'h7;
      `AIP_F_IIR_1:   k = 4'h9;
      default: begin
        k = 4'h1;
        iir_on = 1'b0;
      end
    endcase
    iir_err = {x, {`AIP_IIR_FRAC{1'b0}}} - iir_q[sample_ch];
    iir_d   = iir_q[sample_ch] + (iir_err >>> k);
    // Filter first, then scaling stages, clamp and format
    filt = x;
    if (mode[`AIP_M_FILTER]) begin
      if (fsel == `AIP_F_FIR2)
        filt = fir2[15:0];
      else if (fsel == `AIP_F_AVG50 || fsel == `AIP_F_AVG60)
        filt = sum_d[19:4];
      else if (iir_on)
        filt = iir_d[23:8];
    end
    // The manufacturer stage saturates so the user multiply stays narrow; the user result is saturated only after the clamp
    mfr_w = {{18{filt[15]}}, filt};
    if (mode[`AIP_M_MFR])
      mfr_w = (($signed(mfr_gain_q[sample_ch]) * filt)
              >>> `AIP_MFR_SHIFT)
              + $signed(mfr_ofs_q[sample_ch]);
    m16 = sat16(mfr_w);
    usr_w = {{18{m16[15]}}, m16};
    if (mode[`AIP_M_USER])
      usr_w = (($signed(usr_gain_q[sample_ch]) * m16)
              >>> `AIP_USR_SHIFT)
              + $signed(usr_ofs_q[sample_ch]);
    cl_w  = usr_w;
    over  = 1'b0;
    under = 1'b0;
    if (mode[`AIP_M_RANGE]) begin
      if (usr_w > $signed(upper_q[sample_ch])) begin
        cl_w = $signed(upper_q[sample_ch]);
        over = 1'b1;
      end else if (usr_w < $signed(lower_q[sample_ch])) begin
        cl_w  = $signed(lower_q[sample_ch]);
        under = 1'b1;
      end
    end
    pd = sat16(cl_w);
    cmp1 = `AIP_LIM_OFF;
    cmp2 = `AIP_LIM_OFF;
    if (mode[`AIP_M_LIM1]) begin
      if ($signed(pd) < $signed(lim1_q[sample_ch]))
        cmp1 = `AIP_LIM_BELOW;
      else if ($signed(pd) > $signed(lim1_q[sample_ch]))
        cmp1 = `AIP_LIM_ABOVE;
      else
        cmp1 = `AIP_LIM_EQUAL;
    end
    if (mode[`AIP_M_LIM2]) begin
      if ($signed(pd) < $signed(lim2_q[sample_ch]))
        cmp2 = `AIP_LIM_BELOW;
      else if ($signed(pd) > $signed(lim2_q[sample_ch]))
        cmp2 = `AIP_LIM_ABOVE;
      else
        cmp2 = `AIP_LIM_EQUAL;
    end
    v = pd;
    if (mode[`AIP_M_SIGNMAG] && pd[15])
      v = {1'b1, 15'h0 - pd[14:0]};
    if (mode[`AIP_M_STATLOW])
      v = {v[15:3], 2'h0, over};
  end

  // Sample path state and result register
  always @(posedge clock) begin
    if (reset) begin
      res_valid_q  <= 1'b0;
      res_ch_q     <= {`AIP_CH_W{1'b0}};
      res_data_q   <= 16'h0000;
      res_status_q <= 8'h00;
      for (i = 0; i < NCH; i = i + 1) begin
        ptr_q[i] <= {`AIP_HIST_W{1'b0}};
        sum_q[i] <= 20'sh0;
        iir_q[i] <= 24'sh0;
      end
      for (i = 0; i < NCH*16; i = i + 1)
        hist_q[i] <= 16'sh0;
    end else begin
      res_valid_q <= sample_valid;
      if (sample_valid) begin
        // Filter state runs always, so switching filters is glitch-free
        hist_q[hb | pt]   <= x;
        ptr_q[sample_ch]  <= pt + 4'h1;
        sum_q[sample_ch]  <= sum_d;
        iir_q[sample_ch]  <= iir_d;
        res_ch_q          <= sample_ch;
        res_data_q        <= v;
        res_status_q      <= {1'b0, wdog_exp_q, cmp2, cmp1,
                              over, under};
      end
    end
  end

  // Conversion pacing from channel zero's filter code
  wire [23:0] conv_top;
  assign conv_top = (FOUR_CH == 0 && fsel_q[0] == `AIP_F_AVG60)
                    ? CONV60_CYCLES[23:0] - 24'h1
                    : CONV_CYCLES[23:0] - 24'h1;
  assign conv_req = (conv_cnt_q == 24'h0);

  always @(posedge clock) begin
    if (reset)
      conv_cnt_q <= 24'h0;
    else if (conv_cnt_q >= conv_top)
      conv_cnt_q <= 24'h0;
    else
      conv_cnt_q <= conv_cnt_q + 24'h1;
  end

  // Watchdog: host must refresh the process image in time
  always @(posedge clock) begin
    if (reset) begin
      wdog_cnt_q <= 28'h0;
      wdog_exp_q <= 1'b0;
    end else if (!mode_q[0][`AIP_M_WDOG] || host_refresh) begin
      wdog_cnt_q <= 28'h0;
      wdog_exp_q <= 1'b0;
    end else if (wdog_cnt_q >= WDOG_CYCLES[27:0] - 28'h1) begin
      wdog_exp_q <= 1'b1;
    end else begin
      wdog_cnt_q <= wdog_cnt_q + 28'h1;
    end
  end

  // Register communication
  wire [5:0] ridx;
  wire       racc;
  wire       rwr;
  reg [15:0] rd_d;
  assign ridx = reg_ctrl[5:0];
  assign racc = reg_stb && reg_ctrl[`AIP_C_REG];
  assign rwr  = racc && reg_ctrl[`AIP_C_WR];

  always @* begin
    case (ridx)
      `AIP_IDX_MFR_OFS:  rd_d = mfr_ofs_q[reg_ch];
      `AIP_IDX_MFR_GAIN: rd_d = mfr_gain_q[reg_ch];
      `AIP_IDX_UPPER:    rd_d = upper_q[reg_ch];
      `AIP_IDX_LOWER:    rd_d = lower_q[reg_ch];
      `AIP_IDX_MODE:     rd_d = mode_q[reg_ch];
      `AIP_IDX_USR_OFS:  rd_d = usr_ofs_q[reg_ch];
      `AIP_IDX_USR_GAIN: rd_d = usr_gain_q[reg_ch];
      `AIP_IDX_LIMIT1:   rd_d = lim1_q[reg_ch];
      `AIP_IDX_LIMIT2:   rd_d = lim2_q[reg_ch];
      `AIP_IDX_FILTER:   rd_d = fsel_q[reg_ch];
      default:           rd_d = 16'h0000;
    endcase
  end

  always @(posedge clock) begin
    if (reset) begin
      reg_ack_q    <= 1'b0;
      reg_status_q <= 8'h00;
      reg_rdata_q  <= 16'h0000;
      for (i = 0; i < NCH; i = i + 1) begin
        mode_q[i]     <= `AIP_RST_MODE;
        fsel_q[i]     <= `AIP_RST_FILTER;
        mfr_ofs_q[i]  <= `AIP_RST_MFR_OFS;
        mfr_gain_q[i] <= `AIP_RST_MFR_GAIN;
        upper_q[i]    <= `AIP_RST_UPPER;
        lower_q[i]    <= `AIP_RST_LOWER;
        usr_ofs_q[i]  <= `AIP_RST_USR_OFS;
        usr_gain_q[i] <= `AIP_RST_USR_GAIN;
        lim1_q[i]     <= `AIP_RST_LIMIT;
        lim2_q[i]     <= `AIP_RST_LIMIT;
      end
    end else begin
      reg_ack_q <= racc;
      if (racc) begin
        reg_status_q <= reg_ctrl;
        reg_rdata_q  <= rwr ? 16'h0000 : rd_d;
      end
      if (rwr) begin
        case (ridx)
          `AIP_IDX_MFR_OFS:  mfr_ofs_q[reg_ch]  <= reg_wdata;
          `AIP_IDX_MFR_GAIN: mfr_gain_q[reg_ch] <= reg_wdata;
          `AIP_IDX_UPPER:    upper_q[reg_ch]    <= reg_wdata;
          `AIP_IDX_LOWER:    lower_q[reg_ch]    <= reg_wdata;
          `AIP_IDX_MODE:     mode_q[reg_ch]     <= reg_wdata;
          `AIP_IDX_USR_OFS:  usr_ofs_q[reg_ch]  <= reg_wdata;
          `AIP_IDX_USR_GAIN: usr_gain_q[reg_ch] <= reg_wdata;
          `AIP_IDX_LIMIT1:   lim1_q[reg_ch]     <= reg_wdata;
          `AIP_IDX_LIMIT2:   lim2_q[reg_ch]     <= reg_wdata;
          `AIP_IDX_FILTER:   fsel_q[reg_ch]     <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

endmodule // aip_post_proc

// ### src/aip_defs.vh
// Constants for the analog input post-processing block.
// Assumes a 100 MHz core clock and a dual-channel terminal.
`ifndef AIP_DEFS_VH
`define AIP_DEFS_VH
`define AIP_CLK_MHZ      100
`define AIP_CH_W         1
`define AIP_HIST_W       4
// Register indices, as numbered in the register map
`define AIP_IDX_MFR_OFS  6'h13
`define AIP_IDX_MFR_GAIN 6'h14
`define AIP_IDX_UPPER    6'h15
`define AIP_IDX_LOWER    6'h16
`define AIP_IDX_MODE     6'h20
`define AIP_IDX_USR_OFS  6'h21
`define AIP_IDX_USR_GAIN 6'h22
`define AIP_IDX_LIMIT1   6'h23
`define AIP_IDX_LIMIT2   6'h24
`define AIP_IDX_FILTER   6'h25
// Reset values
`define AIP_RST_MODE     16'h1106
`define AIP_RST_MFR_OFS  16'h0000
`define AIP_RST_MFR_GAIN 16'h2002
`define AIP_RST_UPPER    16'h0fff
`define AIP_RST_LOWER    16'h0000
`define AIP_RST_USR_OFS  16'h0000
`define AIP_RST_USR_GAIN 16'h0100
`define AIP_RST_LIMIT    16'h0000
`define AIP_RST_FILTER   16'h0000
// Mode bit positions
`define AIP_M_USER       0
`define AIP_M_MFR        1
`define AIP_M_WDOG       2
`define AIP_M_SIGNMAG    3
`define AIP_M_STATLOW    4
`define AIP_M_RANGE      8
`define AIP_M_LIM1       9
`define AIP_M_LIM2       10
`define AIP_M_FILTER     11
// Control byte fields
`define AIP_C_REG        7
`define AIP_C_WR         6
// Status byte fields
`define AIP_S_UNDER      0
`define AIP_S_OVER       1
`define AIP_S_ERROR      6
// Comparator codes
`define AIP_LIM_OFF      2'h0
`define AIP_LIM_BELOW    2'h1
`define AIP_LIM_ABOVE    2'h2
`define AIP_LIM_EQUAL    2'h3
// Filter codes
`define AIP_F_FIR2       16'h0000
`define AIP_F_IIR_1K     16'h0100
`define AIP_F_IIR_100    16'h0200
`define AIP_F_IIR_50     16'h0300
`define AIP_F_IIR_20     16'h0400
`define AIP_F_IIR_10     16'h0500
`define AIP_F_IIR_5      16'h0600
`define AIP_F_IIR_1      16'h0700
`define AIP_F_AVG50      16'h1000
`define AIP_F_AVG60      16'h2000
// Scaling weights, as right shifts
`define AIP_MFR_SHIFT    10
`define AIP_USR_SHIFT    8
`define AIP_IIR_FRAC     8
`define AIP_AVG_SHIFT    4
`define AIP_FIR2_SHIFT   2
// Times
`define AIP_CONV_US      2500
`define AIP_CONV60_NS    3125000
`define AIP_WDOG_MS      100
`endif

// ### testbench/aip_post_proc_sva.sv
// Checker for aip_post_proc, watching only its ports.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
module aip_post_proc_sva #(
  parameter integer CONV_CYCLES   = 50,
  parameter integer CONV60_CYCLES = 62
) (
  input logic        clock,
  input logic        reset,
  input logic        conv_req,
  input logic        sample_valid,
  input logic [0:0]  sample_ch,
  input logic        res_valid_q,
  input logic [0:0]  res_ch_q,
  input logic [15:0] res_data_q,
  input logic [7:0]  res_status_q,
  input logic        reg_stb,
  input logic [7:0]  reg_ctrl,
  input logic        reg_ack_q,
  input logic [7:0]  reg_status_q,
  input logic [15:0] reg_rdata_q
);
  logic [15:0] gap_q;
  logic        seen_q;

  // Cycles since the last conversion request
  always_ff @(posedge clock) begin
    if (reset) begin
      gap_q  <= 16'h0000;
      seen_q <= 1'b0;
    end else if (conv_req) begin
      gap_q  <= 16'h0000;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  AST_CONV_GAP: assert property (conv_req && seen_q |->
    gap_q == CONV_CYCLES - 1 || gap_q == CONV60_CYCLES - 1)
    else $error("conversion spacing off");
  AST_CONV_PULSE: assert property (conv_req |=> !conv_req)
    else $error("conversion request too long");
  AST_ACK: assert property (reg_stb && reg_ctrl[7] |=>
    reg_ack_q && reg_status_q == $past(reg_ctrl))
    else $error("register access not answered");
  AST_NO_ACK: assert property (!(reg_stb && reg_ctrl[7]) |=>
    !reg_ack_q) else $error("unrequested register answer");
  AST_WR_ZERO: assert property (reg_stb && reg_ctrl[7:6] == 2'h3 |=>
    reg_rdata_q == 16'h0000) else $error("write returned data");
  AST_RES: assert property (sample_valid |=>
    res_valid_q && res_ch_q == $past(sample_ch))
    else $error("sample result missing");
  AST_HOLD: assert property (!sample_valid |=> !res_valid_q &&
    $stable(res_data_q) && $stable(res_status_q))
    else $error("result changed without sample");
  AST_EXCL: assert property (res_valid_q |->
    !(res_status_q[1] && res_status_q[0]) && !res_status_q[7])
    else $error("status flags conflict");
  AST_RST: assert property (disable iff (1'b0) reset |=>
    !res_valid_q && !reg_ack_q && res_status_q == 8'h00)
    else $error("outputs not cleared by reset");
endmodule // aip_post_proc_sva

// ### testbench/aip_coupler.sv
// Coupler model: refreshes the process image at a steady rate.
// Assumes the bench gates refreshing to starve the watchdog.
`timescale 1ns/1ps
module aip_coupler (
  input  logic clock,
  input  logic reset,
  input  logic refresh_en,
  output logic host_refresh
);
  logic [3:0] tick_q;

  // Refresh every 16 cycles, well inside the watchdog time
  always @(posedge clock) begin
    if (reset) tick_q <= 4'h0;
    else tick_q <= tick_q + 4'h1;
    host_refresh <= !reset && refresh_en && tick_q == 4'hf;
  end
endmodule // aip_coupler

// ### testbench/aip_post_proc_bench.sv
// Bench for aip_post_proc: register setup, sample table, watchdog.
// Assumes shortened conversion and watchdog counts.
`timescale 1ns/1ps
module aip_post_proc_bench;
  typedef struct packed {
    logic [0:0]  ch;
    logic [15:0] mode;
    logic [15:0] filt;
    logic [15:0] din;
    logic [15:0] dout;
    logic [7:0]  st;
  } aip_row_t;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        sample_valid = 1'b0;
  logic [0:0]  sample_ch = 1'h0;
  logic [15:0] sample_data = 16'h0000;
  logic        reg_stb = 1'b0;
  logic [0:0]  reg_ch = 1'h0;
  logic [7:0]  reg_ctrl = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        refresh_en = 1'b1;
  logic        conv_req, host_refresh, res_valid_q, reg_ack_q;
  logic [0:0]  res_ch_q;
  logic [15:0] res_data_q, reg_rdata_q;
  logic [7:0]  res_status_q, reg_status_q;
  int          bad_count = 0;
  int          checks_done = 0;
  int          k_n = 0;
  int          p_n = 0;
  int          q_n = 0;
  aip_row_t    rows [19];

  always #5 clock = ~clock;

  aip_post_proc #(.CONV_CYCLES(50), .CONV60_CYCLES(62),
    .WDOG_CYCLES(100), .FOUR_CH(0)) dut_u (.clock, .reset, .conv_req,
    .sample_valid, .sample_ch, .sample_data, .res_valid_q, .res_ch_q,
    .res_data_q, .res_status_q, .host_refresh, .reg_stb, .reg_ch,
    .reg_ctrl, .reg_wdata, .reg_ack_q, .reg_status_q, .reg_rdata_q);
  aip_coupler cpl_u (.clock, .reset, .refresh_en, .host_refresh);

  task automatic chk(input string nm, input logic [15:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask

  // Answer is fixed at one cycle, so no wait is needed
  task automatic acc(input logic [0:0] ch, input logic [7:0] ctl,
                     input logic [15:0] wd, input logic [15:0] rd);
    @(posedge clock);
    reg_stb   <= 1'b1;
    reg_ch    <= ch;
    reg_ctrl  <= ctl;
    reg_wdata <= wd;
    @(posedge clock);
    reg_stb <= 1'b0;
    #1;
    chk("reg_ack", {15'h0000, ctl[7]}, {15'h0000, reg_ack_q});
    if (ctl[7]) begin
      chk("reg_status", {8'h00, ctl}, {8'h00, reg_status_q});
      chk("reg_rdata", rd, reg_rdata_q);
    end
  endtask

  task automatic put(input logic [0:0] ch, input logic [15:0] d,
                     input logic [15:0] ed, input logic [7:0] es);
    @(posedge clock);
    sample_valid <= 1'b1;
    sample_ch    <= ch;
    sample_data  <= d;
    @(posedge clock);
    sample_valid <= 1'b0;
    #1;
    chk("res_valid", 16'h0001, {15'h0000, res_valid_q});
    chk("res_data", ed, res_data_q);
    chk("res_status", {8'h00, es}, {8'h00, res_status_q});
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    rows[0]  = '{1'h0,16'h0000,16'h0000,16'h0123,16'h0123,8'h00};
    rows[1]  = '{1'h0,16'h0001,16'h0000,16'h0100,16'h0210,8'h00};
    rows[2]  = '{1'h0,16'h0002,16'h0000,16'h0100,16'h0800,8'h00};
    rows[3]  = '{1'h0,16'h0003,16'h0000,16'h0040,16'h0410,8'h00};
    rows[4]  = '{1'h0,16'h0103,16'h0000,16'h0100,16'h0fff,8'h02};
    rows[5]  = '{1'h0,16'h0100,16'h0000,16'hfff0,16'h0000,8'h01};
    rows[6]  = '{1'h0,16'h0200,16'h0000,16'h0080,16'h0080,8'h04};
    rows[7]  = '{1'h0,16'h0200,16'h0000,16'h0100,16'h0100,8'h0c};
    rows[8]  = '{1'h0,16'h0200,16'h0000,16'h0200,16'h0200,8'h08};
    rows[9]  = '{1'h0,16'h0400,16'h0000,16'h0200,16'h0200,8'h30};
    rows[10] = '{1'h0,16'h0600,16'h0000,16'h0300,16'h0300,8'h28};
    rows[11] = '{1'h0,16'h0008,16'h0000,16'hffff,16'h8001,8'h00};
    rows[12] = '{1'h0,16'h0010,16'h0000,16'h0123,16'h0120,8'h00};
    rows[13] = '{1'h0,16'h0110,16'h0000,16'h1000,16'h0ff9,8'h02};
    rows[14] = '{1'h1,16'h0800,16'h0000,16'h0100,16'h0040,8'h00};
    rows[15] = '{1'h1,16'h0800,16'h0000,16'h0100,16'h00c0,8'h00};
    rows[16] = '{1'h1,16'h0800,16'h0000,16'h0100,16'h0100,8'h00};
    rows[17] = '{1'h1,16'h0800,16'h0800,16'h0123,16'h0123,8'h00};
    rows[18] = '{1'h1,16'h0000,16'h0000,16'h0200,16'h0200,8'h00};
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    acc(1'h0, 8'ha0, 16'h0000, 16'h1106);
    acc(1'h1, 8'ha0, 16'h0000, 16'h1106);
    acc(1'h0, 8'ha5, 16'h0000, 16'h0000);
    acc(1'h0, 8'ha2, 16'h0000, 16'h0100);
    acc(1'h0, 8'hbf, 16'h0000, 16'h0000);
    acc(1'h0, 8'h60, 16'hffff, 16'h0000);
    acc(1'h0, 8'ha0, 16'h0000, 16'h1106);
    acc(1'h0, 8'he1, 16'h0010, 16'h0000);
    acc(1'h0, 8'he2, 16'h0200, 16'h0000);
    acc(1'h0, 8'he3, 16'h0100, 16'h0000);
    acc(1'h0, 8'he4, 16'h0200, 16'h0000);
    acc(1'h0, 8'ha3, 16'h0000, 16'h0100);
    foreach (rows[i]) begin
      acc(rows[i].ch, 8'he0, rows[i].mode, 16'h0000);
      acc(rows[i].ch, 8'he5, rows[i].filt, 16'h0000);
      put(rows[i].ch, rows[i].din, rows[i].dout, rows[i].st);
    end
    // Starve the watchdog, then let the coupler refresh again
    acc(1'h0, 8'he0, 16'h0004, 16'h0000);
    refresh_en <= 1'b0;
    repeat (120) @(posedge clock);
    put(1'h0, 16'h0005, 16'h0005, 8'h40);
    refresh_en <= 1'b1;
    repeat (40) @(posedge clock);
    put(1'h0, 16'h0005, 16'h0005, 8'h00);
    // Channel zero's 60 Hz code stretches the conversion period
    acc(1'h0, 8'he5, 16'h2000, 16'h0000);
    for (k_n = 0; k_n < 200 && q_n == 0; k_n++) begin
      @(posedge clock);
      #1;
      if (conv_req && p_n == 0) p_n = k_n + 1;
      else if (conv_req) q_n = k_n + 1;
    end
    chk("conv_gap", 16'h003e, 16'(q_n - p_n));
    test_done();
  end
endmodule // aip_post_proc_bench

bind aip_post_proc aip_post_proc_sva #(.CONV_CYCLES(CONV_CYCLES),
  .CONV60_CYCLES(CONV60_CYCLES)) chk_u (.clock, .reset, .conv_req,
  .sample_valid, .sample_ch, .res_valid_q, .res_ch_q, .res_data_q,
  .res_status_q, .reg_stb, .reg_ctrl, .reg_ack_q, .reg_status_q,
  .reg_rdata_q);
